/* File: hdl/dctc_top.v */
`timescale 1ns/1ps
// Functional notes
// - Writing enable 1 starts the 8-bit counter.
// - 8-bit mode 0 reloads, 1 halts.
// - 8-bit timeout flag set; cleared by writing 1.
// - First 8-bit count may be truncated.
// - 8-bit bit 1 gates timeout interrupt, default 0.
// - 8-bit bit 0 routes counter to pin.
// - Reset loads defaults; starred-twice fields survive recovery.
// - 8-bit clock select sets count clock rate.
// - 16-bit register index 02, bits 4:3 prescale.
// - 16-bit bit 6: reload/single, or edge response.
// - 16-bit bit 2 gates capture interrupt, survives recovery.
// - Writing enable 1 starts the 16-bit counter.
// - Zero to all-ones roll in demodulation still sets the 16-bit timeout flag.
// - 16-bit raises request 3, 8-bit request 4.
`include "dctc_defines.vh"

module dctc_top #(
  parameter W8 = 8,
  parameter W16 = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire stop_recovery,
  input wire [1:0] port_out_data,
  input wire capture_in,
  output reg small_counter_out_pin,
  output reg wide_counter_out_pin,
  output reg small_counter_irq_line,
  output reg wide_counter_irq_line
);

  // Returns one when the free-running divider says a count clock is due.
  function presc_tick;
    input [1:0] sel;
    input [2:0] div;
    begin
      if (sel == `DCTC_DIV1) begin
        presc_tick = 1'b1;
      end else if (sel == `DCTC_DIV2) begin
        presc_tick = div[0];
      end else if (sel == `DCTC_DIV4) begin
        presc_tick = &div[1:0];
      end else begin
        presc_tick = &div;
      end
    end
  endfunction

  // A completed, mapped write whose word index is the wanted register.
  function wr_hit;
    input [2:0] at;
    input [2:0] want;
    input en;
    begin
      wr_hit = en && (at == want);
    end
  endfunction

  // Hardware set wins over a clearing write that lands in the same cycle.
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  reg [2:0] div_r;
  reg run8_r, mode8_r, tout8_r, imask8_r, route8_r;
  reg [1:0] clk8_r;
  reg run16_r, mode16_r, tout16_r, capm16_r, imask16_r, route16_r;
  reg [1:0] clk16_r;
  reg demod_r, capf_r;
  reg [W8-1:0] init8_r, cnt8_r;
  reg [W16-1:0] init16_r, cnt16_r, capt16_r;
  reg out8_r, out16_r, cap_in_d_r;

  wire [2:0] idx = paddr[4:2];
  wire mapped = (paddr[31:5] == 27'h0000000) && (paddr[1:0] == 2'h0) &&
                (idx != 3'h3);
  // A write lands only at the edge where the slave answers.
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite & mapped;
  wire wr8 = wr_hit(idx, `DCTC_IDX_CTL8, wr);
  wire wr16 = wr_hit(idx, `DCTC_IDX_CTL16, wr);
  wire wrm = wr_hit(idx, `DCTC_IDX_MODE, wr);
  wire wri8 = wr_hit(idx, `DCTC_IDX_INIT8, wr);
  wire wri16 = wr_hit(idx, `DCTC_IDX_INIT16, wr);

  wire tick8 = presc_tick(clk8_r, div_r);
  wire tick16 = presc_tick(clk16_r, div_r);
  wire term8 = run8_r & tick8 & (cnt8_r == {W8{1'b0}});
  wire term16 = run16_r & tick16 & (cnt16_r == {W16{1'b0}});
  wire edge16 = capture_in & ~cap_in_d_r;
  wire capt16 = demod_r & run16_r & ~mode16_r & edge16;

  wire [7:0] ctl8_rd = {run8_r, mode8_r, tout8_r, clk8_r, 1'b0, imask8_r, route8_r};
  wire [7:0] ctl16_rd = {run16_r, mode16_r, tout16_r, clk16_r, capm16_r, imask16_r,
                         route16_r};

  // Reserved bits and unmapped slots read as zero.
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    if (idx == `DCTC_IDX_CTL8) begin
      rd_nxt[7:0] = ctl8_rd;
    end else if (idx == `DCTC_IDX_MODE) begin
      rd_nxt[1:0] = {capf_r, demod_r};
    end else if (idx == `DCTC_IDX_CTL16) begin
      rd_nxt[7:0] = ctl16_rd;
    end else if (idx == `DCTC_IDX_INIT8) begin
      rd_nxt[W8-1:0] = init8_r;
    end else if (idx == `DCTC_IDX_INIT16) begin
      rd_nxt[W16-1:0] = init16_r;
    end else if (idx == `DCTC_IDX_COUNT) begin
      rd_nxt = {cnt16_r, 8'h00, cnt8_r};
    end else if (idx == `DCTC_IDX_CAPT) begin
      rd_nxt[W16-1:0] = capt16_r;
    end
  end

  // Each access takes one wait state so that read data comes from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite & mapped) begin
        prdata <= rd_nxt;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // The divider never restarts, so the first count after enabling can be short.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // Fields that survive stop recovery: imask8, clk16, capm16.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask8_r <= 1'b0;
      clk16_r <= `DCTC_RST_CLK;
      capm16_r <= 1'b0;
    end else if (wr8) begin
      imask8_r <= pwdata[`DCTC_B_TMASK];
    end else if (wr16) begin
      clk16_r <= pwdata[`DCTC_B_CLK_HI:`DCTC_B_CLK_LO];
      capm16_r <= pwdata[`DCTC_B_CAPM];
    end
  end

  // The 8-bit counter and its control fields.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run8_r <= 1'b0;
      mode8_r <= 1'b0;
      tout8_r <= 1'b0;
      clk8_r <= `DCTC_RST_CLK;
      route8_r <= 1'b0;
      init8_r <= `DCTC_RST_INIT8;
      cnt8_r <= `DCTC_RST_INIT8;
      out8_r <= 1'b0;
    end else if (stop_recovery) begin
      run8_r <= 1'b0;
      mode8_r <= 1'b0;
      tout8_r <= 1'b0;
      clk8_r <= `DCTC_RST_CLK;
      route8_r <= 1'b0;
      out8_r <= 1'b0;
    end else begin
      // A terminal count in the same cycle as the clearing write keeps the flag.
      tout8_r <= flag_next(tout8_r, term8, wr8 & pwdata[`DCTC_B_TOUT]);
      if (wri8) begin
        init8_r <= pwdata[W8-1:0];
      end
      if (wr8) begin
        mode8_r <= pwdata[`DCTC_B_MODE];
        clk8_r <= pwdata[`DCTC_B_CLK_HI:`DCTC_B_CLK_LO];
        route8_r <= pwdata[`DCTC_B_ROUTE];
        run8_r <= pwdata[`DCTC_B_RUN];
        if (pwdata[`DCTC_B_RUN]) begin
          cnt8_r <= init8_r;
        end
      end else if (term8) begin
        out8_r <= ~out8_r;
        if (mode8_r) begin
          run8_r <= 1'b0;
        end else begin
          cnt8_r <= init8_r;
        end
      end else if (run8_r & tick8) begin
        // Zero never decrements to all-ones, so no false timeout can occur.
        cnt8_r <= cnt8_r - {{(W8-1){1'b0}}, 1'b1};
      end
    end
  end

  // The 16-bit counter, its control fields and the edge capture.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run16_r <= 1'b0;
      mode16_r <= 1'b0;
      tout16_r <= 1'b0;
      imask16_r <= 1'b0;
      route16_r <= 1'b0;
      demod_r <= 1'b0;
      capf_r <= 1'b0;
      init16_r <= `DCTC_RST_INIT16;
      cnt16_r <= `DCTC_RST_INIT16;
      capt16_r <= 16'h0000;
      out16_r <= 1'b0;
      cap_in_d_r <= 1'b0;
    end else if (stop_recovery) begin
      run16_r <= 1'b0;
      mode16_r <= 1'b0;
      tout16_r <= 1'b0;
      imask16_r <= 1'b0;
      route16_r <= 1'b0;
      demod_r <= 1'b0;
      capf_r <= 1'b0;
      out16_r <= 1'b0;
      // The capture input keeps being sampled so no false edge follows recovery.
      cap_in_d_r <= capture_in;
    end else begin
      cap_in_d_r <= capture_in;
      tout16_r <= flag_next(tout16_r, term16, wr16 & pwdata[`DCTC_B_TOUT]);
      capf_r <= flag_next(capf_r, capt16, wrm & pwdata[`DCTC_B_CAPF]);
      if (wrm) begin
        demod_r <= pwdata[`DCTC_B_DEMOD];
      end
      if (wri16) begin
        init16_r <= pwdata[W16-1:0];
      end
      if (wr16) begin
        mode16_r <= pwdata[`DCTC_B_MODE];
        imask16_r <= pwdata[`DCTC_B_TMASK];
        route16_r <= pwdata[`DCTC_B_ROUTE];
        run16_r <= pwdata[`DCTC_B_RUN];
        if (pwdata[`DCTC_B_RUN]) begin
          cnt16_r <= init16_r;
        end
      end else if (capt16) begin
        capt16_r <= cnt16_r;
        cnt16_r <= init16_r;
      end else if (term16) begin
        if (demod_r) begin
          // In demodulation the counter wraps and keeps running.
          cnt16_r <= {W16{1'b1}};
        end else begin
          out16_r <= ~out16_r;
          if (mode16_r) begin
            run16_r <= 1'b0;
          end else begin
            cnt16_r <= init16_r;
          end
        end
      end else if (run16_r & tick16) begin
        cnt16_r <= cnt16_r - {{(W16-1){1'b0}}, 1'b1};
      end
    end
  end

  // Pins and interrupt lines are registered so they never glitch.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      small_counter_out_pin <= 1'b0;
      wide_counter_out_pin <= 1'b0;
      small_counter_irq_line <= 1'b0;
      wide_counter_irq_line <= 1'b0;
    end else begin
      small_counter_out_pin <= route8_r ? out8_r : port_out_data[0];
      wide_counter_out_pin <= route16_r ? out16_r : port_out_data[1];
      small_counter_irq_line <= tout8_r & imask8_r;
      wide_counter_irq_line <= (tout16_r & imask16_r) | (capf_r & capm16_r);
    end
  end

endmodule

/* File: pkg/dctc_defines.vh */
`ifndef DCTC_DEFINES_VH
`define DCTC_DEFINES_VH

// Register indices; the byte address on APB is four times the index.
`define DCTC_IDX_CTL8 3'h0
`define DCTC_IDX_MODE 3'h1
`define DCTC_IDX_CTL16 3'h2
`define DCTC_IDX_INIT8 3'h4
`define DCTC_IDX_INIT16 3'h5
`define DCTC_IDX_COUNT 3'h6
`define DCTC_IDX_CAPT 3'h7

// Field positions in the control registers; CAPM at bit 2 is in the 16-bit one only.
`define DCTC_B_RUN 7
`define DCTC_B_MODE 6
`define DCTC_B_TOUT 5
`define DCTC_B_CLK_HI 4
`define DCTC_B_CLK_LO 3
`define DCTC_B_CAPM 2
`define DCTC_B_TMASK 1
`define DCTC_B_ROUTE 0

// Field positions in the mode register.
`define DCTC_B_DEMOD 0
`define DCTC_B_CAPF 1

// Reset values.
`define DCTC_RST_CLK 2'h0
`define DCTC_RST_INIT8 8'hFF
`define DCTC_RST_INIT16 16'hFFFF

// Prescale selections.
`define DCTC_DIV1 2'h0
`define DCTC_DIV2 2'h1
`define DCTC_DIV4 2'h2
`define DCTC_DIV8 2'h3

`endif

/* File: tb/dctc_chk.sv */
`timescale 1ns/1ps
module dctc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] port_out_data,
  input wire small_counter_out_pin,
  input wire wide_counter_out_pin,
  input wire small_counter_irq_line,
  input wire wide_counter_irq_line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pready && pwrite;
  chk_ready_time:
    assert property (acc && !pready |=> pready) else $error("pready late");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_unmapped_err:
    assert property (acc && pready && paddr[4:2] == 3'h3 |-> pslverr) else $error("no error");
  chk_ctl16_ok:
    assert property (acc && pready && paddr == 32'h8 |-> !pslverr) else $error("ctl16 error");
  chk_irq8_mask:
    assert property (wr && paddr == 32'h0 && !pwdata[1] |=> ##1 !small_counter_irq_line)
      else $error("irq8 not masked");
  chk_irq16_mask:
    assert property (wr && paddr == 32'h8 && pwdata[2:1] == 2'h0 |=> ##1 !wide_counter_irq_line)
      else $error("irq16 not masked");
  chk_route8_port:
    assert property (wr && paddr == 32'h0 && !pwdata[0] |=> ##1
      small_counter_out_pin == $past(port_out_data[0])) else $error("pin8 not port");
  chk_route16_port:
    assert property (wr && paddr == 32'h8 && !pwdata[0] |=> ##1
      wide_counter_out_pin == $past(port_out_data[1])) else $error("pin16 not port");
  cover property (pslverr);
  cover property (small_counter_irq_line);
  cover property (wide_counter_irq_line);
endmodule
bind dctc_top dctc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .port_out_data(port_out_data),
  .small_counter_out_pin(small_counter_out_pin), .wide_counter_out_pin(wide_counter_out_pin),
  .small_counter_irq_line(small_counter_irq_line),
  .wide_counter_irq_line(wide_counter_irq_line));

/* File: tb/dual_counter_timer_control_test.sv */
`timescale 1ns/1ps
module dual_counter_timer_control_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_recovery = 0, cap = 0, e;
  reg [31:0] paddr = 0, pwdata = 0, rd;
  reg [1:0] port_out_data = 0;
  reg [7:0] lfsr = 8'h25;
  wire [31:0] prdata;
  wire pready, pslverr, p8, p16, i8, i16;
  integer mismatches = 0, samples_checked = 0, n, d, k, t;
  always #2.5 pclk = ~pclk;
  dctc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_recovery(stop_recovery), .port_out_data(port_out_data),
    .capture_in(cap), .small_counter_out_pin(p8), .wide_counter_out_pin(p16),
    .small_counter_irq_line(i8), .wide_counter_irq_line(i16));
  function [7:0] nxt(input [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always @(posedge pclk) begin
    lfsr <= nxt(lfsr);
    port_out_data <= lfsr[1:0];
  end
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task give_up;
    begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] ex, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== ex) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task apb(input w, input [31:0] a, input [31:0] wd);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      for (n = 0; n < 20 && pready !== 1'h1; n = n + 1) @(posedge pclk);
      if (n == 20) give_up;
      rd = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask
  task wr(input [31:0] a, input [31:0] dv);
    apb(1'h1, a, dv);
  endtask
  task rc(input [31:0] a, input [31:0] ex);
    begin
      apb(1'h0, a, 32'h0);
      chk("reg", ex, rd);
    end
  endtask
  // The first toggle only synchronises, since the first count may be short.
  task period(input s, input [31:0] ex);
    integer c;
    reg v;
    begin
      v = s ? p16 : p8;
      for (c = 0; c < 300 && (s ? p16 : p8) === v; c = c + 1) @(posedge pclk);
      if (c == 300) give_up;
      v = s ? p16 : p8;
      for (c = 0; c < 300 && (s ? p16 : p8) === v; c = c + 1) @(posedge pclk);
      if (c == 300) give_up;
      chk("period", ex, c);
    end
  endtask
  task one_shot(input [31:0] a, input s);
    begin
      wr(a, 32'h02);
      wr(a, 32'h22);
      rc(a, 32'h02);
      wr(a, 32'hC2);
      for (t = 0; t < 99 && (s ? i16 : i8) !== 1'h1; t = t + 1) @(posedge pclk);
      if (t == 99) give_up;
      chk("irq", 32'h1, s ? i16 : i8);
      rc(a, 32'h62);
      wr(a, 32'h42);
      rc(a, 32'h62);
      wr(a, 32'h40);
      rc(a, 32'h60);
      chk("irq", 32'h0, s ? i16 : i8);
      wr(a, 32'h20);
      rc(a, 32'h0);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc(32'h0, 32'h0);
    rc(32'h8, 32'h0);
    rc(32'h10, 32'hFF);
    rc(32'h14, 32'hFFFF);
    apb(1'h0, 32'hC, 32'h0);
    chk("err", 32'h1, e);
    for (d = 0; d < 4; d = d + 1) begin
      k = lfsr[2:0] + 1;
      wr(32'h10, k);
      wr(32'h14, k);
      wr(32'h0, 32'h81 | d << 3);
      wr(32'h8, 32'h81 | d << 3);
      period(1'h0, (k + 1) << d);
      period(1'h1, (k + 1) << d);
      rc(32'h0, 32'hA1 | d << 3);
      rc(32'h8, 32'hA1 | d << 3);
    end
    one_shot(32'h0, 1'h0);
    one_shot(32'h8, 1'h1);
    wr(32'h0, 32'h1B);
    wr(32'h8, 32'h1F);
    stop_recovery <= 1'h1;
    @(posedge pclk);
    stop_recovery <= 1'h0;
    rc(32'h0, 32'h02);
    rc(32'h8, 32'h1C);
    rc(32'h18, 32'h0);
    wr(32'h14, 32'h40);
    wr(32'h4, 32'h1);
    wr(32'h8, 32'h84);
    // Four count ticks separate the enabling write from the sampled edge.
    repeat (3) @(posedge pclk);
    cap <= 1'h1;
    rc(32'h1C, 32'h3C);
    rc(32'h4, 32'h3);
    chk("irq", 32'h1, i16);
    wr(32'h4, 32'h3);
    rc(32'h4, 32'h1);
    chk("irq", 32'h0, i16);
    wr(32'h8, 32'hC4);
    cap <= 1'h0;
    @(posedge pclk);
    cap <= 1'h1;
    rc(32'h4, 32'h1);
    rc(32'h1C, 32'h3C);
    print_verdict;
  end
endmodule
